// >>> logic/msu_map.vh
/*
 Constants for the miscellaneous system instruction unit: operation
 codes, special register selects, bus offsets and field positions.
 Assumes the decode stage delivers one operation code per issue.
*/
`ifndef MSU_MAP_VH
`define MSU_MAP_VH

// ============================================================
// Operation codes
`define MSU_OP_NO_OPERATION 4'h0
`define MSU_OP_BREAKPOINT 4'h1
`define MSU_OP_CHG_STATE 4'h2
`define MSU_OP_DMEM_BAR 4'h3
`define MSU_OP_DSYNC_BAR 4'h4
`define MSU_OP_ISYNC_BAR 4'h5
`define MSU_OP_MOVE_FROM 4'h6
`define MSU_OP_MOVE_TO 4'h7
`define MSU_OP_SEND_EVT 4'h8
`define MSU_OP_SUPER_CALL 4'h9
`define MSU_OP_WAIT_EVT 4'ha
`define MSU_OP_WAIT_INT 4'hb
`define MSU_OP_FP_STORE 4'hc
`define MSU_OP_FP_SUB 4'hd

// ============================================================
// Special register selects
`define MSU_SR_APP 3'h0
`define MSU_SR_PRI 3'h1
`define MSU_SR_BASE 3'h2
`define MSU_SR_BMAX 3'h3
`define MSU_SR_FAULT 3'h4
`define MSU_SR_OTHER 3'h5

// ============================================================
// Bus map and fields
`define MSU_CTRL_OFF 8'h00
`define MSU_STAT_OFF 8'h04
`define MSU_CTRL_SOP 0
`define MSU_ST_EVT 0
`define MSU_ST_SLP 1
`define MSU_ST_BUSY 2
`define MSU_ST_PRI 3
`define MSU_ST_FLT 4
`define MSU_ST_FENCE 5
`define MSU_ST_BP_LO 8
`define MSU_ST_BP_HI 15
`define MSU_CTRL_RST 1'h0
`define MSU_BP_RST 8'h00

`endif

// >>> logic/msu_core.v
/*
 Miscellaneous system instruction unit with an AHB-Lite slave for its
 control and status words. Assumes the issue port, memory system and
 exception logic share clk; one issue at a time, only while idle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msu_map.vh"

module msu_core (
  input wire clk,
  input wire reset,
  input wire issueValid,
  input wire [3:0] issueOp,
  input wire condPass,
  input wire privileged,
  input wire [7:0] imm8,
  input wire maskSet,
  input wire selPriMask,
  input wire selFaultMask,
  input wire [2:0] specSel,
  input wire regIsSpPc,
  input wire [31:0] gprSrc,
  input wire [31:0] baseAddr,
  input wire offAdd,
  input wire [31:0] fpSrcA,
  input wire [31:0] fpSrcB,
  input wire [31:0] extSpecIn,
  input wire memIdle,
  input wire memAck,
  input wire excPending,
  input wire excNewPend,
  input wire dbgReq,
  input wire dbgEnabled,
  input wire extEvent,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  output reg busy,
  output reg instDone,
  output reg gprWe,
  output reg [31:0] gprData,
  output reg fpWe,
  output reg [31:0] fpData,
  output reg memReq,
  output reg [31:0] memAddr,
  output reg [31:0] memData,
  output reg memFence,
  output reg dbgEnter,
  output reg svcRaise,
  output reg eventOut,
  output reg flushPipe,
  output reg flagsWe,
  output reg [4:0] flagsOut,
  output reg priority_mask_bit,
  output reg fault_mask_bit,
  output reg [7:0] base_priority_reg,
  output reg specWe,
  output reg [31:0] specData,
  output reg sleeping
);

  // ============================================================
  // States
  localparam S_IDLE = 2'h0;
  localparam S_STORE = 2'h1;
  localparam S_BARRIER = 2'h2;
  localparam S_SLEEP = 2'h3;

  reg [1:0] state_r;
  reg eventReg_r;
  reg sleepIntr_r;
  reg evtOnPend_r;
  reg apSel_r;
  reg apWrite_r;
  reg [7:0] apAddr_r;

  // ============================================================
  // Single precision add, truncating; no NaN handling, trades
  // rounding accuracy for a compact datapath
  function [31:0] fpAdd;
    input [31:0] x;
    input [31:0] y;
    reg [31:0] a;
    reg [31:0] b;
    reg [7:0] ea;
    reg [7:0] eb;
    reg [7:0] d;
    reg [24:0] ma;
    reg [24:0] mb;
    reg [24:0] m;
    reg [8:0] e;
    integer i;
    begin
      if (x[30:0] < y[30:0])
      begin
        a = y;
        b = x;
      end
      else
      begin
        a = x;
        b = y;
      end
      ea = a[30:23];
      eb = b[30:23];
      ma = {1'b0, (ea != 8'h00), a[22:0]};
      mb = {1'b0, (eb != 8'h00), b[22:0]};
      d = ea - eb;
      mb = (d > 8'h18) ? 25'h0000000 : (mb >> d);
      m = (a[31] == b[31]) ? ma + mb : ma - mb;
      e = {1'b0, ea};
      if (m[24])
      begin
        m = m >> 1;
        e = e + 9'h001;
      end
      for (i = 0; i < 24; i = i + 1)
        if (!m[23] && (m != 25'h0000000) && (e > 9'h001))
        begin
          m = m << 1;
          e = e - 9'h001;
        end
      if (!m[23])
        e = 9'h000;
      if (m == 25'h0000000)
        fpAdd = 32'h00000000;
      else if (e >= 9'h0ff)
        fpAdd = {a[31], 8'hff, 23'h000000};
      else
        fpAdd = {a[31], e[7:0], m[22:0]};
    end
  endfunction

  // ============================================================
  // Special register read; alias reads base priority
  function [31:0] specRead;
    input [2:0] sel;
    begin
      case (sel)
        `MSU_SR_APP: specRead = {flagsOut, 27'h0000000};
        `MSU_SR_PRI: specRead = {31'h00000000, priority_mask_bit};
        `MSU_SR_BASE: specRead = {24'h000000, base_priority_reg};
        `MSU_SR_BMAX: specRead = {24'h000000, base_priority_reg};
        `MSU_SR_FAULT: specRead = {31'h00000000, fault_mask_bit};
        default: specRead = extSpecIn;
      endcase
    end
  endfunction

  // ============================================================
  // Issue and wake decode
  wire take = issueValid && (state_r == S_IDLE);
  wire exec = take && (condPass || (issueOp == `MSU_OP_BREAKPOINT)
    || (issueOp == `MSU_OP_CHG_STATE));
  wire sendExec = exec && (issueOp == `MSU_OP_SEND_EVT);
  wire evtWaitNow = exec && (issueOp == `MSU_OP_WAIT_EVT) && eventReg_r;
  wire evtWake = excPending || (excNewPend && evtOnPend_r)
    || (dbgReq && dbgEnabled) || extEvent;
  wire intWake = excPending || dbgReq;
  wire wakeNow = sleepIntr_r ? intWake : evtWake;
  wire bpCondOk = (gprSrc[7:0] != 8'h00)
    && ((base_priority_reg == 8'h00) || (gprSrc[7:0] < base_priority_reg));
  wire [31:0] offset = {22'h000000, imm8, 2'b00};
  wire [31:0] ctrlWord = {31'h00000000, evtOnPend_r};
  wire [31:0] statWord = {16'h0000, base_priority_reg, 2'b00, memFence,
    fault_mask_bit, priority_mask_bit, busy, sleeping, eventReg_r};
  wire ctrlWrNow = apSel_r && apWrite_r && (apAddr_r == `MSU_CTRL_OFF);

  // ============================================================
  // Event register; a set in the clearing cycle wins
  always @(posedge clk or posedge reset)
    if (reset)
      eventReg_r <= 1'b0;
    else if (sendExec || extEvent)
      eventReg_r <= 1'b1;
    else if (evtWaitNow)
      eventReg_r <= 1'b0;

  // ============================================================
  // Register bus slave; always ready, always OKAY
  always @(posedge clk or posedge reset)
    if (reset)
    begin
      apSel_r <= 1'b0;
      apWrite_r <= 1'b0;
      apAddr_r <= 8'h00;
      evtOnPend_r <= `MSU_CTRL_RST;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end
    else
    begin
      apSel_r <= hsel && htrans[1] && hready;
      apWrite_r <= hwrite;
      apAddr_r <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ctrlWrNow)
        evtOnPend_r <= hwdata[`MSU_CTRL_SOP];
      hrdata <= 32'h00000000;
      // Forward a write still in its data phase to a following read
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        if ({haddr[7:2], 2'b00} == `MSU_CTRL_OFF)
          hrdata <= ctrlWrNow ? {31'h00000000, hwdata[0]} : ctrlWord;
        else if ({haddr[7:2], 2'b00} == `MSU_STAT_OFF)
          hrdata <= statWord;
      end
    end

  // ============================================================
  // Execution
  always @(posedge clk or posedge reset)
    if (reset)
    begin
      state_r <= S_IDLE;
      sleepIntr_r <= 1'b0;
      busy <= 1'b0;
      instDone <= 1'b0;
      gprWe <= 1'b0;
      gprData <= 32'h00000000;
      fpWe <= 1'b0;
      fpData <= 32'h00000000;
      memReq <= 1'b0;
      memAddr <= 32'h00000000;
      memData <= 32'h00000000;
      memFence <= 1'b0;
      dbgEnter <= 1'b0;
      svcRaise <= 1'b0;
      eventOut <= 1'b0;
      flushPipe <= 1'b0;
      flagsWe <= 1'b0;
      flagsOut <= 5'h00;
      priority_mask_bit <= 1'b0;
      fault_mask_bit <= 1'b0;
      base_priority_reg <= `MSU_BP_RST;
      specWe <= 1'b0;
      specData <= 32'h00000000;
      sleeping <= 1'b0;
    end
    else
    begin
      instDone <= 1'b0;
      gprWe <= 1'b0;
      fpWe <= 1'b0;
      dbgEnter <= 1'b0;
      svcRaise <= 1'b0;
      eventOut <= 1'b0;
      flushPipe <= 1'b0;
      flagsWe <= 1'b0;
      specWe <= 1'b0;
      // Fence only holds later accesses, other work goes on
      if (exec && (issueOp == `MSU_OP_DMEM_BAR) && !memIdle)
        memFence <= 1'b1;
      else if (memIdle)
        memFence <= 1'b0;
      case (state_r)
        S_IDLE:
          if (take && !exec)
            instDone <= 1'b1;
          else if (exec)
          begin
            case (issueOp)
              `MSU_OP_BREAKPOINT:
              begin
                dbgEnter <= 1'b1;
                instDone <= 1'b1;
              end
              `MSU_OP_CHG_STATE:
              begin
                if (privileged && selPriMask)
                  priority_mask_bit <= maskSet;
                if (privileged && selFaultMask)
                  fault_mask_bit <= maskSet;
                instDone <= 1'b1;
              end
              `MSU_OP_DMEM_BAR:
                instDone <= 1'b1;
              `MSU_OP_DSYNC_BAR:
              begin
                state_r <= S_BARRIER;
                busy <= 1'b1;
              end
              `MSU_OP_ISYNC_BAR:
              begin
                flushPipe <= 1'b1;
                instDone <= 1'b1;
              end
              `MSU_OP_MOVE_FROM:
              begin
                gprWe <= !regIsSpPc;
                gprData <= specRead(specSel);
                instDone <= 1'b1;
              end
              `MSU_OP_MOVE_TO:
              begin
                if (!regIsSpPc)
                  case (specSel)
                    `MSU_SR_APP:
                    begin
                      flagsOut <= gprSrc[31:27];
                      flagsWe <= 1'b1;
                    end
                    `MSU_SR_PRI:
                      if (privileged)
                        priority_mask_bit <= gprSrc[0];
                    `MSU_SR_BASE:
                      if (privileged)
                        base_priority_reg <= gprSrc[7:0];
                    `MSU_SR_BMAX:
                      if (privileged && bpCondOk)
                        base_priority_reg <= gprSrc[7:0];
                    `MSU_SR_FAULT:
                      if (privileged)
                        fault_mask_bit <= gprSrc[0];
                    default:
                      if (privileged)
                      begin
                        specWe <= 1'b1;
                        specData <= gprSrc;
                      end
                  endcase
                instDone <= 1'b1;
              end
              `MSU_OP_SEND_EVT:
              begin
                eventOut <= 1'b1;
                instDone <= 1'b1;
              end
              `MSU_OP_SUPER_CALL:
              begin
                svcRaise <= 1'b1;
                instDone <= 1'b1;
              end
              `MSU_OP_WAIT_EVT:
                if (eventReg_r)
                  instDone <= 1'b1;
                else
                begin
                  state_r <= S_SLEEP;
                  sleepIntr_r <= 1'b0;
                  sleeping <= 1'b1;
                  busy <= 1'b1;
                end
              `MSU_OP_WAIT_INT:
              begin
                state_r <= S_SLEEP;
                sleepIntr_r <= 1'b1;
                sleeping <= 1'b1;
                busy <= 1'b1;
              end
              `MSU_OP_FP_STORE:
              begin
                state_r <= S_STORE;
                busy <= 1'b1;
                memAddr <= offAdd ? baseAddr + offset
                  : baseAddr - offset;
                memData <= fpSrcA;
              end
              `MSU_OP_FP_SUB:
              begin
                fpWe <= 1'b1;
                fpData <= fpAdd(fpSrcA,
                  {~fpSrcB[31], fpSrcB[30:0]});
                instDone <= 1'b1;
              end
              default:
                instDone <= 1'b1;
            endcase
          end
        S_STORE:
          // A pending fence holds the store back
          if (memReq && memAck)
          begin
            memReq <= 1'b0;
            state_r <= S_IDLE;
            busy <= 1'b0;
            instDone <= 1'b1;
          end
          else if (!memReq && !memFence)
            memReq <= 1'b1;
        S_BARRIER:
          if (memIdle)
          begin
            state_r <= S_IDLE;
            busy <= 1'b0;
            instDone <= 1'b1;
          end
        S_SLEEP:
          if (wakeNow)
          begin
            state_r <= S_IDLE;
            sleeping <= 1'b0;
            busy <= 1'b0;
            instDone <= 1'b1;
          end
        default:
          state_r <= S_IDLE;
      endcase
    end

endmodule
`default_nettype wire

// >>> testbench/msu_props.sv
/*
 Checker for the system instruction unit issue port and sleep logic.
 Assumes the bind below and the operation codes of msu_map.vh.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msu_map.vh"

module msu_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic issueValid,
  input wire logic [3:0] issueOp,
  input wire logic condPass,
  input wire logic privileged,
  input wire logic maskSet,
  input wire logic selPriMask,
  input wire logic excPending,
  input wire logic excNewPend,
  input wire logic dbgReq,
  input wire logic extEvent,
  input wire logic busy,
  input wire logic instDone,
  input wire logic memReq,
  input wire logic memFence,
  input wire logic dbgEnter,
  input wire logic svcRaise,
  input wire logic eventOut,
  input wire logic flagsWe,
  input wire logic priority_mask_bit,
  input wire logic fault_mask_bit,
  input wire logic sleeping
);
  // ============================================================
  // Issue and sleep properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence iss(logic [3:0] op);
    issueValid && !busy && issueOp == op;
  endsequence
  // Wake inputs all low, so sleep must persist
  sequence quiet;
    sleeping && !excPending && !excNewPend && !dbgReq && !extEvent;
  endsequence
  brk_debug_a: assert property (iss(`MSU_OP_BREAKPOINT)
    |=> dbgEnter && instDone) else $error("no debug entry");
  call_raise_a: assert property (iss(`MSU_OP_SUPER_CALL)
    ##0 condPass |=> svcRaise) else $error("no supervisor call");
  send_event_a: assert property (iss(`MSU_OP_SEND_EVT)
    ##0 condPass |=> eventOut && instDone) else $error("no event pulse");
  mask_unpriv_a: assert property (iss(`MSU_OP_CHG_STATE)
    ##0 !privileged |=> $stable(priority_mask_bit) && $stable(fault_mask_bit))
    else $error("mask moved");
  mask_set_a: assert property (iss(`MSU_OP_CHG_STATE)
    ##0 privileged && maskSet && selPriMask |=> priority_mask_bit)
    else $error("mask not set");
  flags_kept_a: assert property (issueValid && !busy &&
    issueOp <= `MSU_OP_WAIT_INT && issueOp != `MSU_OP_MOVE_TO |=> !flagsWe)
    else $error("flags written");
  sleep_hold_a: assert property (quiet |=> sleeping)
    else $error("woke without cause");
  wake_done_a: assert property (sleeping && excPending
    |=> instDone && !sleeping) else $error("no wake on exception");
  store_req_a: assert property (iss(`MSU_OP_FP_STORE) ##0 condPass
    && !memFence |=> ##1 memReq) else $error("store not requested");
endmodule

bind msu_core msu_props u_props (.*);
`default_nettype wire

// >>> testbench/msu_mem_model.sv
/*
 Memory system model: acknowledges stores lat+1 cycles after the request and keeps
 unrelated accesses outstanding for hold cycles when load is pulsed.
*/
`timescale 1ns/100ps
`default_nettype none

module msu_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic memReq,
  input wire logic [3:0] lat,
  input wire logic load,
  input wire logic [7:0] hold,
  output logic memAck,
  output logic memIdle
);
  // ============================================================
  // Outstanding accesses and store acknowledge
  logic [3:0] waitCnt;
  logic [7:0] outst;
  assign memIdle = outst == 8'h00 && !memReq;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      waitCnt <= 4'h0;
      outst <= 8'h00;
      memAck <= 1'b0;
    end
    else
    begin
      memAck <= memReq && !memAck && waitCnt == lat;
      waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
      outst <= load ? hold : outst - {7'h00, outst != 8'h00};
    end
  end
endmodule
`default_nettype wire

// >>> testbench/misc_system_instruction_unit_tb.sv
/*
 Self-checking bench for the system instruction unit.
 Assumes msu_core, msu_mem_model and msu_map.vh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msu_map.vh"

module misc_system_instruction_unit_tb;
  logic clk, reset, issueValid, condPass, privileged, maskSet, selPriMask;
  logic selFaultMask, regIsSpPc, offAdd, memIdle, memAck, excPending;
  logic excNewPend, dbgReq, dbgEnabled, extEvent, hsel, hwrite, hready;
  logic hreadyout, hresp, busy, instDone, gprWe, fpWe, memReq, memFence;
  logic dbgEnter, svcRaise, eventOut, flushPipe, flagsWe, priority_mask_bit;
  logic fault_mask_bit, specWe, sleeping, load;
  logic [3:0] issueOp, lat;
  logic [7:0] imm8, base_priority_reg, hold;
  logic [2:0] specSel, hsize;
  logic [1:0] htrans;
  logic [4:0] flagsOut;
  logic [6:0] pv;
  logic [31:0] gprSrc, baseAddr, fpSrcA, fpSrcB, extSpecIn, haddr, hwdata;
  logic [31:0] hrdata, gprData, fpData, memAddr, memData, specData, rd;
  int n_mismatch, cmp_count;
  assign hready = hreadyout;
  msu_core u_dut (.*);
  msu_mem_model u_mem (.*);
  always #10 clk = ~clk;

  // ============================================================
  // Shared tasks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task start(input logic [3:0] op, input logic cp);
    @(posedge clk);
    issueValid <= 1'b1;
    issueOp <= op;
    condPass <= cp;
    @(posedge clk);
    issueValid <= 1'b0;
    #1;
  endtask
  task fin();
    int n;
    n = 0;
    while (instDone !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    pv = {dbgEnter, svcRaise, eventOut, flushPipe, flagsWe, gprWe, fpWe};
    chk(n < 300, 1);
  endtask
  task run(input logic [3:0] op, input logic cp);
    start(op, cp);
    fin();
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Wake source k: 0 event, 1 debug, 2 new pend, 3 exception
  task slp(input logic [3:0] op, input int k);
    start(op, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk(sleeping, 1);
    @(posedge clk);
    {excPending, excNewPend, dbgReq, extEvent} <= 4'h1 << k;
    @(posedge clk);
    {excPending, excNewPend, dbgReq, extEvent} <= 4'h0;
    #1;
    chk(instDone, 1);
  endtask

  // ============================================================
  // Scenarios
  task t_evt();
    slp(`MSU_OP_WAIT_EVT, 0);
    ahb(1'b0, `MSU_STAT_OFF, 0);
    chk(rd[`MSU_ST_EVT], 1);
    chk(hresp, 0);
    start(`MSU_OP_WAIT_EVT, 1'b1);
    chk(instDone, 1);
    ahb(1'b0, `MSU_STAT_OFF, 0);
    chk(rd[`MSU_ST_EVT], 0);
    run(`MSU_OP_SEND_EVT, 1'b1);
    chk(pv, 7'h10);
    slp(`MSU_OP_WAIT_INT, 1);
    slp(`MSU_OP_WAIT_INT, 3);
    run(`MSU_OP_WAIT_EVT, 1'b1);
    ahb(1'b1, `MSU_CTRL_OFF, 1);
    ahb(1'b1, 32'h40, 32'hffff_ffff);
    ahb(1'b0, 32'h40, 0);
    chk(rd, 0);
    slp(`MSU_OP_WAIT_EVT, 2);
  endtask
  task t_ops();
    @(posedge clk);
    imm8 <= 8'hff;
    run(`MSU_OP_BREAKPOINT, 1'b0);
    chk(pv, 7'h40);
    run(`MSU_OP_SUPER_CALL, 1'b1);
    chk(pv, 7'h20);
    run(`MSU_OP_ISYNC_BAR, 1'b1);
    chk(pv, 7'h08);
    run(`MSU_OP_NO_OPERATION, 1'b1);
    chk(pv, 7'h00);
  endtask
  task t_cps();
    @(posedge clk);
    {privileged, maskSet, selPriMask, selFaultMask} <= 4'hf;
    run(`MSU_OP_CHG_STATE, 1'b0);
    chk({priority_mask_bit, fault_mask_bit}, 2'h3);
    @(posedge clk);
    {privileged, maskSet} <= 2'h0;
    run(`MSU_OP_CHG_STATE, 1'b1);
    chk({priority_mask_bit, fault_mask_bit}, 2'h3);
    @(posedge clk);
    {privileged, selPriMask} <= 2'h2;
    run(`MSU_OP_CHG_STATE, 1'b1);
    chk({priority_mask_bit, fault_mask_bit}, 2'h2);
  endtask
  task t_spec();
    @(posedge clk);
    specSel <= `MSU_SR_BASE;
    gprSrc <= 32'h40;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk(base_priority_reg, 8'h40);
    @(posedge clk);
    specSel <= `MSU_SR_BMAX;
    gprSrc <= 32'h20;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk(base_priority_reg, 8'h20);
    @(posedge clk);
    gprSrc <= 32'h30;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk(base_priority_reg, 8'h20);
    @(posedge clk);
    gprSrc <= 32'h0;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk(base_priority_reg, 8'h20);
    run(`MSU_OP_MOVE_FROM, 1'b1);
    chk({gprData, pv}, {32'h20, 7'h02});
    @(posedge clk);
    regIsSpPc <= 1'b1;
    run(`MSU_OP_MOVE_FROM, 1'b1);
    chk(pv, 7'h00);
    @(posedge clk);
    regIsSpPc <= 1'b0;
    specSel <= `MSU_SR_OTHER;
    gprSrc <= 32'h0000_0abc;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk(specData, 32'h0000_0abc);
    @(posedge clk);
    privileged <= 1'b0;
    specSel <= `MSU_SR_BASE;
    gprSrc <= 32'hf800_0011;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk(base_priority_reg, 8'h20);
    @(posedge clk);
    specSel <= `MSU_SR_APP;
    run(`MSU_OP_MOVE_TO, 1'b1);
    chk({flagsOut, pv}, {5'h1f, 7'h04});
  endtask
  task t_mem();
    @(posedge clk);
    {fpSrcA, fpSrcB} <= {32'h4040_0000, 32'h3f80_0000};
    {baseAddr, imm8, offAdd, lat} <= {32'h1000, 8'h04, 1'b0, 4'h6};
    run(`MSU_OP_FP_SUB, 1'b1);
    chk(fpData, 32'h4000_0000);
    run(`MSU_OP_FP_STORE, 1'b1);
    chk({memAddr, memData}, {32'h0ff0, 32'h4040_0000});
    @(posedge clk);
    {hold, load} <= {8'h0c, 1'b1};
    @(posedge clk);
    load <= 1'b0;
    run(`MSU_OP_DSYNC_BAR, 1'b1);
    chk(u_mem.outst, 0);
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    run(`MSU_OP_DMEM_BAR, 1'b1);
    start(`MSU_OP_FP_STORE, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    chk(memReq, 0);
    fin();
  endtask

  // ============================================================
  // Sequence and verdict
  task finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {clk, issueValid, condPass, privileged, maskSet, selPriMask} = 0;
    {selFaultMask, regIsSpPc, offAdd, excPending, excNewPend, dbgReq} = 0;
    {dbgEnabled, extEvent, hsel, hwrite, load, issueOp, imm8} = 0;
    {specSel, hsize, htrans, gprSrc, baseAddr, fpSrcA, fpSrcB} = 0;
    {extSpecIn, haddr, hwdata, lat, hold} = 0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_evt();
    t_ops();
    t_cps();
    t_spec();
    t_mem();
    finish_test();
  end
  // Whole run is well under two thousand cycles
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
